// file: rtl/cmc_counter_mode_control.sv
`timescale 1ns/100ps
`default_nettype none
module cmc_counter_mode_control
    import cmc_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // clock and reset
    input  wire logic                       clock_i,
    input  wire logic                       nrst_i,
    // special function register port
    input  wire logic [7:0]                 sfr_addr_i,
    input  wire logic                       sfr_wr_i,
    input  wire logic                       sfr_rd_i,
    input  wire logic [7:0]                 sfr_wdata_i,
    output logic      [7:0]                 sfr_rdata_o,
    // system events, same clock
    input  wire logic                       cpu_idle_i,
    input  wire logic                       timer0_ovf_i,
    input  wire logic [CMC_NUM_MODULES-1:0] match_event_i,
    input  wire logic [CMC_NUM_MODULES-1:0] match_irq_en_i,
    // pins
    input  wire logic                       external_count_input_i,
    input  wire logic                       ext_clk_div8_src_i,
    // status
    output logic      [CNT_W-1:0]           count_o,
    output logic                            ovf_irq_o,
    output logic                            match_irq_o,
    output logic                            watchdog_active_o
);

    initial begin
        if (CNT_W != 16) begin
            $error("cmc_counter_mode_control: CNT_W must be 16");
        end
    end

    cmc_state_t st;
    cmc_state_t next_st;

    logic       tick;
    logic       run;
    logic       div4_en;
    logic       ext_fall;
    logic       ext_rise;
    logic       wr_mode;
    logic       wr_ctrl;
    logic [7:0] hw_set;
    logic [7:0] new_mode;

    // ===================================================
    // next state
    always_comb begin
        next_st = st;
        // pins: the first sync stage feeds only the second
        next_st.eci_sync = {st.eci_sync[0], external_count_input_i};
        next_st.ext_sync = {st.ext_sync[0], ext_clk_div8_src_i};

        next_st.pre12 = (st.pre12 == CMC_DIV12_LAST) ? 4'h0 : st.pre12 + 4'h1;
        div4_en = (st.pre12[1:0] == CMC_DIV4_LAST);

        // external count input edges sampled at a quarter of sysclk only
        ext_fall = 1'b0;
        if (div4_en) begin
            next_st.eci_sample = st.eci_sync[1];
            ext_fall = st.eci_sample & ~st.eci_sync[1];
        end

        // divide the synchronised external clock by eight
        next_st.ext_prev = st.ext_sync[1];
        ext_rise = st.ext_sync[1] & ~st.ext_prev;
        if (ext_rise) begin
            next_st.ext_div = st.ext_div + 3'h1;
        end

        case (st.mode[CMC_MODE_TB_LSB +: 3])
            CMC_TB_DIV12:   tick = (st.pre12 == CMC_DIV12_LAST);
            CMC_TB_DIV4:    tick = div4_en;
            CMC_TB_T0_OVF:  tick = timer0_ovf_i;
            CMC_TB_EXT_CNT: tick = ext_fall;
            CMC_TB_SYSCLK:  tick = 1'b1;
            CMC_TB_EXT_DIV: tick = ext_rise && (st.ext_div == CMC_EXT_LAST);
            default:        tick = 1'b0;  // reserved codes stop the count
        endcase

        // idle halts only when suspend is asked for
        run = st.control[CMC_CTRL_RUN]
              && !(cpu_idle_i && st.mode[CMC_MODE_IDLE_SUSPEND]);

        hw_set = 8'h00;
        hw_set[CMC_NUM_MODULES-1:0] = match_event_i;
        if (run && tick) begin
            next_st.count = st.count + 16'h0001;
            if (st.count == 16'hFFFF) begin
                hw_set[CMC_CTRL_OVF_FLAG] = 1'b1;
            end
        end

        wr_ctrl = sfr_wr_i && (sfr_addr_i == CMC_ADDR_CONTROL);
        wr_mode = sfr_wr_i && (sfr_addr_i == CMC_ADDR_MODE);

        // a flag set in the same cycle as a clear survives
        if (wr_ctrl) begin
            next_st.control = sfr_wdata_i | hw_set;
        end else begin
            next_st.control = st.control | hw_set;
        end

        new_mode = st.mode;
        if (wr_mode) begin
            if (st.mode[CMC_MODE_WDT_ENABLE]) begin
                // only watchdog disable or lock may pass
                if (!st.mode[CMC_MODE_WDT_LOCK]) begin
                    new_mode[CMC_MODE_WDT_ENABLE] =
                        sfr_wdata_i[CMC_MODE_WDT_ENABLE];
                end
                new_mode[CMC_MODE_WDT_LOCK] = st.mode[CMC_MODE_WDT_LOCK]
                    | sfr_wdata_i[CMC_MODE_WDT_LOCK];
            end else begin
                new_mode = sfr_wdata_i;
                // lock is sticky until reset
                new_mode[CMC_MODE_WDT_LOCK] = st.mode[CMC_MODE_WDT_LOCK]
                    | sfr_wdata_i[CMC_MODE_WDT_LOCK];
            end
        end
        new_mode[CMC_MODE_UNUSED] = 1'b0;
        next_st.mode = new_mode;

        if (sfr_rd_i) begin
            case (sfr_addr_i)
                CMC_ADDR_CONTROL: next_st.rdata = st.control;
                CMC_ADDR_MODE:    next_st.rdata = st.mode;
                default:          next_st.rdata = 8'h00;
            endcase
        end

        next_st.ovf_irq = next_st.control[CMC_CTRL_OVF_FLAG]
                          && next_st.mode[CMC_MODE_OVF_IRQ_EN];
        next_st.match_irq = |(next_st.control[CMC_NUM_MODULES-1:0]
                              & match_irq_en_i);
        next_st.wdt_active = next_st.mode[CMC_MODE_WDT_ENABLE];
    end

    // ===================================================
    // state register
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st         <= '0;
            st.mode    <= CMC_MODE_RESET;
            st.control <= CMC_CTRL_RESET;
            st.count   <= CMC_CNT_RESET;
            st.wdt_active <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign sfr_rdata_o       = st.rdata;
    assign count_o           = st.count;
    assign ovf_irq_o         = st.ovf_irq;
    assign match_irq_o       = st.match_irq;
    assign watchdog_active_o = st.wdt_active;

endmodule
`default_nettype wire

// file: rtl/cmc_pkg.sv
// Function
// - module match sets its flag sticky; flag with enable requests interrupt; software clears.
// - in cpu idle the counter runs if idle_suspend is 0, halts if 1.
// - watchdog_enable_bit set makes module 5 the watchdog; cleared means inactive.
// - once watchdog_lock is set, clearing watchdog_enable_bit is refused until reset.
// - mode bit 4 always reads zero; writes to it are ignored.
// - timebase_select picks sysclk/12, /4, timer0 overflow, external falls, sysclk, ext/8.
// - external clock divided by eight is synchronised to sysclk before counting.
// - overflow interrupt only when overflow_flag and overflow_irq_enable are both set.
// - while watchdog_enable_bit is 1, mode writes are ignored except clearing it (if not locked) and setting watchdog_lock.
// - mode register resets with the watchdog enable bit set.
// - counter advances only while run_enable is 1, else holds.
package cmc_pkg;

    // ===================================================
    // register map
    localparam logic [7:0] CMC_ADDR_CONTROL = 8'hD8;
    localparam logic [7:0] CMC_ADDR_MODE    = 8'hD9;
    localparam logic [7:0] CMC_MODE_RESET   = 8'h40;
    localparam logic [7:0] CMC_CTRL_RESET   = 8'h00;

    // ===================================================
    // mode fields
    localparam int CMC_MODE_IDLE_SUSPEND = 7;
    localparam int CMC_MODE_WDT_ENABLE   = 6;
    localparam int CMC_MODE_WDT_LOCK     = 5;
    localparam int CMC_MODE_UNUSED       = 4;
    localparam int CMC_MODE_TB_LSB       = 1;
    localparam int CMC_MODE_OVF_IRQ_EN   = 0;

    // ===================================================
    // control fields
    localparam int CMC_CTRL_OVF_FLAG = 7;
    localparam int CMC_CTRL_RUN      = 6;
    localparam int CMC_NUM_MODULES   = 6;

    // ===================================================
    // timebase codes and prescaler counts
    localparam logic [2:0] CMC_TB_DIV12   = 3'h0;
    localparam logic [2:0] CMC_TB_DIV4    = 3'h1;
    localparam logic [2:0] CMC_TB_T0_OVF  = 3'h2;
    localparam logic [2:0] CMC_TB_EXT_CNT = 3'h3;
    localparam logic [2:0] CMC_TB_SYSCLK  = 3'h4;
    localparam logic [2:0] CMC_TB_EXT_DIV = 3'h5;
    localparam logic [3:0] CMC_DIV12_LAST = 4'hB;
    localparam logic [1:0] CMC_DIV4_LAST  = 2'h3;
    localparam logic [2:0] CMC_EXT_LAST   = 3'h7;
    localparam logic [15:0] CMC_CNT_RESET = 16'h0000;

    typedef struct packed {
        logic [1:0]  eci_sync;
        logic        eci_sample;
        logic [1:0]  ext_sync;
        logic        ext_prev;
        logic [2:0]  ext_div;
        logic [3:0]  pre12;
        logic [7:0]  mode;
        logic [7:0]  control;
        logic [15:0] count;
        logic [7:0]  rdata;
        logic        ovf_irq;
        logic        match_irq;
        logic        wdt_active;
    } cmc_state_t;

endpackage

// file: testbench/cmc_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module cmc_assertions
    import cmc_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic                       clock_i,
    input wire logic                       nrst_i,
    input wire logic [7:0]                 sfr_addr_i,
    input wire logic                       sfr_wr_i,
    input wire logic                       sfr_rd_i,
    input wire logic [7:0]                 sfr_wdata_i,
    input wire logic [7:0]                 sfr_rdata_o,
    input wire logic [CMC_NUM_MODULES-1:0] match_event_i,
    input wire logic [CMC_NUM_MODULES-1:0] match_irq_en_i,
    input wire logic [CNT_W-1:0]           count_o,
    input wire logic                       match_irq_o,
    input wire logic                       watchdog_active_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    wire logic mode_wr = sfr_wr_i && sfr_addr_i == CMC_ADDR_MODE;
    wire logic mode_rd = sfr_rd_i && sfr_addr_i == CMC_ADDR_MODE;
    // =========================================================
    // properties
    sequence s_match;
        |(match_event_i & match_irq_en_i) ##1 $stable(match_irq_en_i);
    endsequence
    // enable held steady, so only a write could drop the request
    sequence s_held;
        match_irq_o && !sfr_wr_i && $stable(match_irq_en_i)
            ##1 $stable(match_irq_en_i);
    endsequence
    chk_match_sets:
        assert property (s_match |-> match_irq_o)
        else $error("match request missing");
    chk_match_sticky:
        assert property (s_held |-> match_irq_o)
        else $error("match request dropped");
    chk_wdt_reset:
        assert property ($rose(nrst_i) |-> watchdog_active_o)
        else $error("watchdog off after reset");
    chk_count_step:
        assert property (!$stable(count_o) |-> count_o == $past(count_o) + 1'b1)
        else $error("counter skipped");
    chk_wdt_hold:
        assert property (watchdog_active_o
            && !(mode_wr && !sfr_wdata_i[CMC_MODE_WDT_ENABLE])
            |=> watchdog_active_o) else $error("watchdog dropped");
    chk_wdt_off:
        assert property (!watchdog_active_o
            && !(mode_wr && sfr_wdata_i[CMC_MODE_WDT_ENABLE])
            |=> !watchdog_active_o) else $error("watchdog woke");
    chk_rd_unused:
        assert property (mode_rd |=> !sfr_rdata_o[CMC_MODE_UNUSED])
        else $error("unused mode bit set");
    chk_rd_watchdog_enable_bit:
        assert property (mode_rd && watchdog_active_o ##1 watchdog_active_o
            |-> sfr_rdata_o[CMC_MODE_WDT_ENABLE]) else $error("enable bit low");
endmodule
bind cmc_counter_mode_control cmc_assertions #(.CNT_W(CNT_W)) u_chk (
    .clock_i(clock_i), .nrst_i(nrst_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_rdata_o(sfr_rdata_o), .match_event_i(match_event_i),
    .match_irq_en_i(match_irq_en_i), .count_o(count_o),
    .match_irq_o(match_irq_o), .watchdog_active_o(watchdog_active_o));
`default_nettype wire

// file: testbench/cmc_counter_mode_control_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module cmc_counter_mode_control_tb_top;
    import cmc_pkg::*;
    logic        clock_i = 0, nrst_i = 0, wr = 0, rd = 0, idle = 0, t0 = 0;
    logic        external_count_input = 0, exs = 0;
    logic [7:0]  addr = 0, wd = 0, rdat;
    logic [5:0]  mev = 0;
    logic [15:0] cnt, c0;
    logic        ovf, mirq, wdt;
    int          err_total = 0, n_tests = 0;
    // rows: write flag, address, data, expected read
    localparam logic [24:0] ROWS [9] = '{
        {1'b0, 8'hD9, 8'h00, 8'h40}, {1'b0, 8'hD8, 8'h00, 8'h00},
        {1'b1, 8'h55, 8'hFF, 8'h00}, {1'b0, 8'h55, 8'h00, 8'h00},
        {1'b1, 8'hD9, 8'h8F, 8'h00}, {1'b0, 8'hD9, 8'h00, 8'h00},
        {1'b1, 8'hD9, 8'h9B, 8'h00}, {1'b0, 8'hD9, 8'h00, 8'h8B},
        {1'b1, 8'hD9, 8'h09, 8'h00}};
    cmc_counter_mode_control u_cmc_counter_mode_control (
        .clock_i(clock_i), .nrst_i(nrst_i), .sfr_addr_i(addr),
        .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wd), .sfr_rdata_o(rdat),
        .cpu_idle_i(idle), .timer0_ovf_i(t0), .match_event_i(mev),
        .match_irq_en_i(6'h3F), .external_count_input_i(external_count_input),
        .ext_clk_div8_src_i(exs), .count_o(cnt), .ovf_irq_o(ovf),
        .match_irq_o(mirq), .watchdog_active_o(wdt));
    always #2.5 clock_i = ~clock_i;
    // =========================================================
    // tasks
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task automatic chk(input logic [15:0] g, e);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wrt(input logic [7:0] a, d);
        // an edge passes with the strobe low before the next request
        wr = 1; addr = a; wd = d; tick(1); wr = 0; tick(1);
    endtask
    task automatic rdc(input logic [7:0] a, e);
        rd = 1; addr = a; tick(1); rd = 0; chk(rdat, e); tick(1);
    endtask
    task automatic give_verdict;
        if (err_total == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // =========================================================
    // sequence
    initial begin
        tick(4); nrst_i = 1; tick(1);
        chk(wdt, 1);
        foreach (ROWS[i]) begin
            if (ROWS[i][24]) wrt(ROWS[i][23:16], ROWS[i][15:8]);
            else rdc(ROWS[i][23:16], ROWS[i][7:0]);
        end
        c0 = cnt; tick(5); chk(cnt, c0);
        wrt(8'hD8, 8'h40);
        for (int i = 0; i < 70000 && cnt !== 16'hFFFF; i++) tick(1);
        tick(3); chk(ovf, 1);
        rdc(8'hD8, 8'hC0);
        wrt(8'hD9, 8'h08); tick(2); chk(ovf, 0);
        wrt(8'hD8, 8'h40);
        wrt(8'hD9, 8'h88); idle = 1; tick(2);
        c0 = cnt; tick(5); chk(cnt, c0);
        wrt(8'hD9, 8'h08); tick(3);
        c0 = cnt; tick(4); chk(cnt, c0 + 16'h4);
        wrt(8'hD9, 8'h04); tick(3); c0 = cnt;
        repeat (3) begin t0 = 1; tick(1); t0 = 0; tick(2); end
        tick(3); chk(cnt, c0 + 16'h3);
        for (int c = 0; c < 8; c++) begin
            wrt(8'hD9, {4'h0, 3'(c), 1'b0}); rdc(8'hD9, {4'h0, 3'(c), 1'b0});
        end
        mev = 6'h04; tick(1); mev = 0; tick(3);
        chk(mirq, 1); rdc(8'hD8, 8'h44);
        tick(4); chk(mirq, 1); wrt(8'hD8, 8'h40); tick(1); chk(mirq, 0);
        wrt(8'hD9, 8'h60); wrt(8'hD9, 8'h00); rdc(8'hD9, 8'h60);
        chk(wdt, 1); nrst_i = 0; tick(2); nrst_i = 1; tick(1);
        rdc(8'hD9, 8'h40); wrt(8'hD9, 8'h00); rdc(8'hD9, 8'h00);
        chk(wdt, 0);
        wrt(8'hD8, 8'h40); wrt(8'hD9, 8'h02); tick(3);
        c0 = cnt; tick(8); chk(cnt, c0 + 16'h2);
        wrt(8'hD9, 8'h00); tick(3);
        c0 = cnt; tick(24); chk(cnt, c0 + 16'h2);
        wrt(8'hD9, 8'h06); tick(3); c0 = cnt;
        repeat (3) begin external_count_input = 1; tick(8); external_count_input = 0; tick(12); end
        chk(cnt, c0 + 16'h3);
        wrt(8'hD9, 8'h0A); tick(3); c0 = cnt;
        repeat (16) begin exs = 1; tick(3); exs = 0; tick(3); end
        tick(4); chk(cnt, c0 + 16'h2);
        give_verdict();
    end
    initial begin
        #450000;
        err_total++;
        give_verdict();
    end
endmodule
`default_nettype wire
